// ---- logic/adc_seq_pkg.sv ----
// Package for the converter sequencer control: register map, fields, states.
// Assumes a 40 MHz system clock and a plain one-cycle register port.
package adc_seq_pkg;
   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_LIMITS = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_RESULT0 = 8'h18;
   localparam logic [7:0] OFS_RESULT8 = 8'h38;
   localparam logic [7:0] OFS_SLOT_LOW = 8'h5C;
   localparam logic [7:0] OFS_SLOT_HIGH = 8'h60;
   localparam logic [7:0] OFS_SLOT_COUNT = 8'h64;
   localparam logic [7:0] OFS_SLOT_MODE = 8'h68;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CFG_WIN_EN = 1;
   localparam int CFG_ENABLE = 0;
   localparam int CR_ALIGN = 11;
   localparam int CR_MODE_LO = 9;
   localparam int CR_GO = 8;
   localparam int CR_TRG_EN = 2;
   localparam int CR_WIN_IE = 1;
   localparam int CR_DONE_IE = 0;
   localparam int CR_CMPCH_LO = 12;
   localparam int CR_TRGH_LO = 17;
   localparam int CR_TRGL_LO = 4;
   localparam int ST_OVR_LO = 20;
   localparam int ST_VAL_LO = 8;
   localparam int ST_CHAN_LO = 4;
   localparam int ST_BUSY = 2;
   localparam int ST_WIN = 1;
   localparam int ST_DONE = 0;
   localparam int RES_VALID = 21;
   localparam int RES_OVR = 20;
   localparam int RES_CHAN_LO = 16;
   localparam int LIM_UP_LO = 16;
   localparam int NCHAN = 9;
   localparam int ALIGN_SHIFT = 4;
   localparam logic [31:0] CONTROL_MASK = 32'h0006_FF77;
   localparam logic [31:0] CONFIG_MASK = 32'h0000_0003;
   localparam logic [31:0] LIMITS_MASK = 32'h0FFF_0FFF;
   localparam logic [3:0] SLOT_COUNT_MAX = 4'h8;
   localparam logic [3:0] CMPCH_ALL = 4'hF;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // ---------------------------------------------------------------
   // Modes, trigger codes, states
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MODE_SINGLE = 2'b00,
      MODE_ONE_PASS = 2'b01,
      MODE_CONTINUOUS = 2'b10,
      MODE_RESERVED = 2'b11
   } conv_mode_t;
   localparam logic [4:0] TRG_TIMER_A_COMPARE_ONE = 5'h00;
   localparam logic [4:0] TRG_TIMER_A_TRIGGER_OUT = 5'h08;
   localparam logic [4:0] TRG_TIMER_A_COMPARE_FIVE = 5'h11;
   localparam int NTRIG = 18;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_WAIT = 2'b10
   } seq_state_t;
   // Request to and answer from the analog core
   typedef struct packed
   {
      logic start;
      logic [3:0] channel;
   } core_req_t;
   typedef struct packed
   {
      logic done;
      logic [11:0] data;
   } core_ans_t;
endpackage

// ---- logic/adc_sequencer_control.sv ----
// Digital control of a 12-bit nine-channel converter: modes, triggers,
// window comparator, status, results and arbitrary slot sequence.
// Assumes an analog core on clk_sys that answers each start with one done
// pulse, and trigger lines from outside this clock's domain.
//
// Operation
// - Alignment bit 1 gives left-justified result, 0 right-justified.
// - Mode field: 00 single, 01 one pass, 10 continuous; 11 reserved.
// - Single and one-pass modes clear the start bit when conversion ends.
// - Continuous mode converts until software writes start 0 or reset.
// - Trigger source is a five-bit code from bits 18:17 and 6:4.
// - Trigger enable 1 lets the selected trigger start conversions.
// - Window and done interrupts requested only while their enables are set.
// - Limit register: upper limit bits 27:16, lower limit bits 11:0.
// - Upper >= lower: flag when result >= upper or result < lower.
// - Upper < lower: flag when result equals upper or lies between.
// - Done flag sets when a single-mode conversion or a whole channel group finishes.
// - Writing 1 clears window or done flag; 0 leaves it.
// - Status shows overrun flags at 28:20, valid flags at 16:8.
// - Busy bit 2; channel field 7:4 shows current or next channel.
// - Nine four-bit slot selectors in two selection registers.
// - Slot settings shadowed; active copy loads when last channel starts.
// - Slot count n uses slots 0 to n; above 8 invalid.
// - Slot mode enable takes scan channels from slot settings.
// - Window comparison runs only while its enable bit is set.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module adc_sequencer_control
   import adc_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic [NTRIG-1:0] trigLines,
   input wire logic [8:0] chanEnable,
   output core_req_t coreReq,
   input wire core_ans_t coreAns,
   output logic irq
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [4:0] trig_code(input logic [31:0] cr);
      trig_code = {cr[CR_TRGH_LO+1:CR_TRGH_LO], cr[CR_TRGL_LO+2:CR_TRGL_LO]};
   endfunction

   function automatic logic [3:0] slot_chan(input logic [31:0] lo, input logic [3:0] hi,
                                            input logic [3:0] idx);
      if (idx >= 4'h8)
         slot_chan = hi;
      else
         slot_chan = lo[idx[2:0]*4 +: 4];
   endfunction

   function automatic logic [3:0] next_enabled(input logic [8:0] en, input logic [3:0] from);
      logic [3:0] c;
      next_enabled = 4'h0;
      for (int i = 8; i >= 0; i--)
      begin
         c = 4'(i);
         if (en[i] && c >= from)
            next_enabled = c;
      end
   endfunction

   function automatic logic [3:0] last_enabled(input logic [8:0] en);
      last_enabled = 4'h0;
      for (int i = 0; i < NCHAN; i++)
         if (en[i])
            last_enabled = 4'(i);
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [31:0] config_r;
   logic [31:0] control_r;
   logic [31:0] limits_r;
   logic winFlag_r;
   logic doneFlag_r;
   logic [11:0] resData_r [NCHAN];
   logic [8:0] resValid_r;
   logic [8:0] resOvr_r;
   logic [31:0] slotLowAct_r;
   logic [31:0] slotLowSh_r;
   logic [3:0] slotHighAct_r;
   logic [3:0] slotHighSh_r;
   logic [3:0] slotCountAct_r;
   logic [3:0] slotCountSh_r;
   logic slotMode_r;
   seq_state_t state_r;
   logic [3:0] pos_r;
   logic [3:0] chan_r;
   logic [NTRIG-1:0] trigMeta_r;
   logic [NTRIG-1:0] trigSync_r;
   logic [NTRIG-1:0] trigPrev_r;

   logic busy;
   logic wrCtl;
   logic goStart;
   logic [4:0] trgSel;
   logic trigHit;
   logic [3:0] lastPos;
   logic lastStep;
   logic [3:0] chanAt;
   conv_mode_t mode;
   logic [11:0] upper;
   logic [11:0] lower;
   logic [11:0] conv;
   logic winHit;
   logic [3:0] resIdx;
   logic resRd;

   assign busy = (state_r != ST_IDLE);
   assign wrCtl = regWrite && regAddr == OFS_CONTROL;
   assign mode = conv_mode_t'(control_r[CR_MODE_LO+1:CR_MODE_LO]);
   assign trgSel = trig_code(control_r);
   assign upper = limits_r[LIM_UP_LO+11:LIM_UP_LO];
   assign lower = limits_r[11:0];
   assign conv = coreAns.data;
   assign resIdx = 4'((regAddr - OFS_RESULT0) >> 2);
   assign resRd = regRead && regAddr >= OFS_RESULT0 && regAddr <= OFS_RESULT8
                  && regAddr[1:0] == 2'b00;

   // ---------------------------------------------------------------
   // Trigger synchroniser and edge detect
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         trigMeta_r <= '0;
         trigSync_r <= '0;
         trigPrev_r <= '0;
      end
      else
      begin
         trigMeta_r <= trigLines;
         trigSync_r <= trigMeta_r;
         trigPrev_r <= trigSync_r;
      end
   end

   // Codes outside the table never fire
   assign trigHit = control_r[CR_TRG_EN] && int'(trgSel) < NTRIG
                    && trigSync_r[trgSel] && !trigPrev_r[trgSel];

   // ---------------------------------------------------------------
   // Sequence planning
   // ---------------------------------------------------------------
   always_comb
   begin
      if (slotMode_r)
      begin
         lastPos = (slotCountAct_r > SLOT_COUNT_MAX) ? SLOT_COUNT_MAX : slotCountAct_r;
         chanAt = slot_chan(slotLowAct_r, slotHighAct_r, pos_r);
      end
      else
      begin
         lastPos = last_enabled(chanEnable);
         chanAt = next_enabled(chanEnable, pos_r);
      end
      // Normal scan steps by channel number, slot scan by slot position
      lastStep = (mode == MODE_SINGLE) || ((slotMode_r ? pos_r : chan_r) >= lastPos);
   end

   assign goStart = config_r[CFG_ENABLE] && control_r[CR_GO] && mode != MODE_RESERVED
                    && (!control_r[CR_TRG_EN] || trigHit);

   // ---------------------------------------------------------------
   // Sequencer state machine
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         state_r <= ST_IDLE;
         pos_r <= 4'h0;
         chan_r <= 4'h0;
         coreReq <= '0;
      end
      else
      begin
         coreReq.start <= 1'b0;
         unique case (state_r)
            ST_IDLE:
            begin
               chan_r <= chanAt;
               if (goStart)
               begin
                  coreReq.start <= 1'b1;
                  coreReq.channel <= chanAt;
                  chan_r <= chanAt;
                  state_r <= ST_CONVERT;
               end
            end
            ST_CONVERT:
            begin
               if (coreAns.done)
               begin
                  if (!lastStep)
                  begin
                     pos_r <= slotMode_r ? pos_r + 4'h1 : chan_r + 4'h1;
                     state_r <= ST_WAIT;
                  end
                  else
                  begin
                     pos_r <= 4'h0;
                     state_r <= (mode == MODE_CONTINUOUS) ? ST_WAIT : ST_IDLE;
                  end
               end
            end
            ST_WAIT:
            begin
               // Continuous scan stops here once software drops the start bit
               if (!control_r[CR_GO])
                  state_r <= ST_IDLE;
               else
               begin
                  coreReq.start <= 1'b1;
                  coreReq.channel <= chanAt;
                  chan_r <= chanAt;
                  state_r <= ST_CONVERT;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Control and configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         config_r <= RESET_WORD;
         control_r <= RESET_WORD;
         limits_r <= RESET_WORD;
      end
      else
      begin
         if (regWrite && regAddr == OFS_CONFIG)
            config_r <= regWdata & CONFIG_MASK;
         if (regWrite && regAddr == OFS_LIMITS)
            limits_r <= regWdata & LIMITS_MASK;
         if (wrCtl)
            control_r <= regWdata & CONTROL_MASK;
         else if (state_r == ST_CONVERT && coreAns.done && lastStep
                  && mode != MODE_CONTINUOUS)
            control_r[CR_GO] <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Slot registers with shadows
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         slotLowAct_r <= RESET_WORD;
         slotLowSh_r <= RESET_WORD;
         slotHighAct_r <= 4'h0;
         slotHighSh_r <= 4'h0;
         slotCountAct_r <= 4'h0;
         slotCountSh_r <= 4'h0;
         slotMode_r <= 1'b0;
      end
      else
      begin
         if (regWrite && regAddr == OFS_SLOT_MODE)
            slotMode_r <= regWdata[0];
         if (regWrite && regAddr == OFS_SLOT_LOW)
         begin
            slotLowSh_r <= regWdata;
            if (!busy)
               slotLowAct_r <= regWdata;
         end
         if (regWrite && regAddr == OFS_SLOT_HIGH)
         begin
            slotHighSh_r <= regWdata[3:0];
            if (!busy)
               slotHighAct_r <= regWdata[3:0];
         end
         if (regWrite && regAddr == OFS_SLOT_COUNT)
         begin
            slotCountSh_r <= regWdata[3:0];
            if (!busy)
               slotCountAct_r <= regWdata[3:0];
         end
         // Last channel starting: shadows take over for the next pass
         if (busy && coreReq.start && lastStep)
         begin
            slotLowAct_r <= slotLowSh_r;
            slotHighAct_r <= slotHighSh_r;
            slotCountAct_r <= slotCountSh_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // Results, flags
   // ---------------------------------------------------------------
   always_comb
   begin
      if (upper >= lower)
         winHit = (conv >= upper) || (conv < lower);
      else
         winHit = (conv == upper) || (conv > upper && conv < lower);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         resValid_r <= '0;
         resOvr_r <= '0;
         for (int i = 0; i < NCHAN; i++)
            resData_r[i] <= 12'h000;
      end
      else
      begin
         for (int i = 0; i < NCHAN; i++)
         begin
            if (resRd && resIdx == 4'(i))
            begin
               resValid_r[i] <= 1'b0;
               resOvr_r[i] <= 1'b0;
            end
            // A load in the same cycle as the read wins
            if (state_r == ST_CONVERT && coreAns.done && chan_r == 4'(i))
            begin
               resData_r[i] <= conv;
               resValid_r[i] <= 1'b1;
               resOvr_r[i] <= resValid_r[i] && !(resRd && resIdx == 4'(i));
            end
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         winFlag_r <= 1'b0;
         doneFlag_r <= 1'b0;
      end
      else
      begin
         // Set beats clear in the same cycle
         if (regWrite && regAddr == OFS_STATUS && regWdata[ST_WIN])
            winFlag_r <= 1'b0;
         if (regWrite && regAddr == OFS_STATUS && regWdata[ST_DONE])
            doneFlag_r <= 1'b0;
         if (state_r == ST_CONVERT && coreAns.done && config_r[CFG_WIN_EN]
             && (control_r[CR_CMPCH_LO+3:CR_CMPCH_LO] == chan_r
                 || control_r[CR_CMPCH_LO+3:CR_CMPCH_LO] == CMPCH_ALL) && winHit)
            winFlag_r <= 1'b1;
         if (state_r == ST_CONVERT && coreAns.done && lastStep)
            doneFlag_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt request and read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         irq <= 1'b0;
      else
         irq <= (winFlag_r && control_r[CR_WIN_IE])
                || (doneFlag_r && control_r[CR_DONE_IE]);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         regRdata <= RESET_WORD;
      else
      begin
         regRdata <= RESET_WORD;
         if (regRead)
         begin
            if (resRd)
            begin
               regRdata[RES_VALID] <= resValid_r[resIdx];
               regRdata[RES_OVR] <= resOvr_r[resIdx];
               if (control_r[CR_ALIGN])
                  regRdata[15:0] <= {resData_r[resIdx], 4'h0};
               else
                  regRdata[15:0] <= {4'h0, resData_r[resIdx]};
            end
            else
               unique case (regAddr)
                  OFS_CONFIG: regRdata <= config_r;
                  OFS_CONTROL: regRdata <= control_r;
                  OFS_LIMITS: regRdata <= limits_r;
                  OFS_STATUS:
                  begin
                     regRdata[ST_OVR_LO+8:ST_OVR_LO] <= resOvr_r;
                     regRdata[ST_VAL_LO+8:ST_VAL_LO] <= resValid_r;
                     regRdata[ST_CHAN_LO+3:ST_CHAN_LO] <= chan_r;
                     regRdata[ST_BUSY] <= busy;
                     regRdata[ST_WIN] <= winFlag_r;
                     regRdata[ST_DONE] <= doneFlag_r;
                  end
                  OFS_SLOT_LOW: regRdata <= slotLowSh_r;
                  OFS_SLOT_HIGH: regRdata[3:0] <= slotHighSh_r;
                  OFS_SLOT_COUNT: regRdata[3:0] <= slotCountSh_r;
                  OFS_SLOT_MODE: regRdata[0] <= slotMode_r;
                  default: regRdata <= RESET_WORD;
               endcase
         end
      end
   end
endmodule

// ---- sim/adc_sequencer_control_properties.sv ----
// Checker for the converter sequencer control, bound to its top module.
// Assumes the one-cycle register port and a core answering each start once.
`timescale 1ns/1ps
module adc_sequencer_control_properties
   import adc_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   input wire logic [NTRIG-1:0] trigLines,
   input wire logic [8:0] chanEnable,
   input wire core_req_t coreReq,
   input wire core_ans_t coreAns,
   input wire logic irq
);
   // ---------------------------------------------------------------
   // Helper state and assertions
   // ---------------------------------------------------------------
   logic pend_r;
   logic [1:0] ieBits_r;
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         pend_r <= 1'b0;
      else if (coreReq.start)
         pend_r <= 1'b1;
      else if (coreAns.done)
         pend_r <= 1'b0;
   end
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         ieBits_r <= 2'b00;
      else if (regWrite && regAddr == OFS_CONTROL)
         ieBits_r <= regWdata[1:0];
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_read_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
      else $error("read data outside answer cycle");
   a_start_pulse: assert property (coreReq.start |=> !coreReq.start)
      else $error("start longer than one cycle");
   a_start_idle: assert property (coreReq.start |-> !pend_r)
      else $error("start while core busy");
   a_chan_hold: assert property (pend_r |-> $stable(coreReq.channel))
      else $error("channel moved during conversion");
   a_irq_gate: assert property ((ieBits_r == 2'b00) [*2] |-> !irq)
      else $error("irq with both enables clear");
   a_busy_chan: assert property (regRead && regAddr == OFS_STATUS && pend_r |=>
      regRdata[ST_BUSY] && regRdata[7:4] == $past(coreReq.channel))
      else $error("status busy or channel wrong");
   a_result_clear: assert property (!coreAns.done ##1 (regRead && regAddr >= OFS_RESULT0
      && regAddr <= OFS_RESULT8 && !coreAns.done) ##1 !coreAns.done
      ##1 (regRead && regAddr == $past(regAddr, 2)) |=> regRdata[21:20] == 2'b00)
      else $error("result flags not cleared by read");
   a_flag_clear: assert property (!coreAns.done ##1 (regWrite && regAddr == OFS_STATUS
      && regWdata[1:0] == 2'b11 && !coreAns.done) ##1 !coreAns.done
      ##1 (regRead && regAddr == OFS_STATUS) |=> regRdata[1:0] == 2'b00)
      else $error("status flags not cleared");
   a_unmapped_read: assert property (regRead && (regAddr == 8'h0C || regAddr >= 8'h6C)
      |=> regRdata == 32'h0)
      else $error("unmapped read not zero");
   a_limits_back: assert property (regWrite && regAddr == OFS_LIMITS ##1 !regWrite
      ##1 (regRead && regAddr == OFS_LIMITS) |=> regRdata == ($past(regWdata, 3) & LIMITS_MASK))
      else $error("limit readback wrong");
endmodule
bind adc_sequencer_control adc_sequencer_control_properties chk (.clk_sys(clk_sys),
   .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
   .regRead(regRead), .regRdata(regRdata), .trigLines(trigLines),
   .chanEnable(chanEnable), .coreReq(coreReq), .coreAns(coreAns), .irq(irq));

// ---- sim/analog_core_model.sv ----
// Behavioural model of the analog core facing the sequencer.
// Assumes one-cycle start pulses; the bench sets answer delay and value.
`timescale 1ns/1ps
module analog_core_model
   import adc_seq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire core_req_t req,
   input wire logic [11:0] value,
   input wire logic [3:0] lat,
   output core_ans_t ans
);
   // ---------------------------------------------------------------
   // Conversion timer
   // ---------------------------------------------------------------
   core_ans_t ans_r = '0;
   logic [3:0] cnt_r = 4'h0;
   logic [3:0] ch_r = 4'h0;
   assign ans = ans_r;
   // Data toggles outside answers so stale samples are caught
   always @(posedge clk_sys)
   begin
      ans_r.done <= 1'b0;
      ans_r.data <= ~ans_r.data;
      if (!resetn)
         cnt_r <= 4'h0;
      else if (req.start)
      begin
         cnt_r <= lat;
         ch_r <= req.channel;
      end
      else if (cnt_r == 4'h1)
      begin
         ans_r.done <= 1'b1;
         ans_r.data <= value + {8'h00, ch_r};
         cnt_r <= 4'h0;
      end
      else if (cnt_r != 4'h0)
         cnt_r <= cnt_r - 4'h1;
   end
endmodule

// ---- sim/test_adc_sequencer_control.sv ----
// Self-checking bench for the converter sequencer control.
// Assumes the core model answers with value plus channel number.
`timescale 1ns/1ps
module test_adc_sequencer_control
   import adc_seq_pkg::*;
;
   // ---------------------------------------------------------------
   // Stimulus, tasks and tests
   // ---------------------------------------------------------------
   typedef struct {logic [11:0] up; logic [11:0] low; logic [11:0] dat; logic al; logic we;
      logic [1:0] ie; logic win;} row_t;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [31:0] regRdata;
   logic [NTRIG-1:0] trigLines = '0;
   logic [8:0] chanEnable = 9'h001;
   core_req_t coreReq;
   core_ans_t coreAns;
   logic irq;
   logic [11:0] value = 12'h000;
   logic [3:0] lat = 4'h1;
   logic [3:0] starts[$];
   int num_errors = 0;
   int num_checks = 0;
   logic [4:0] codes[3] = '{5'h00, 5'h08, 5'h11};
   logic [7:0] regs[7] = '{OFS_CONFIG, OFS_CONTROL, OFS_LIMITS, OFS_STATUS, OFS_SLOT_LOW,
      OFS_SLOT_COUNT, OFS_SLOT_MODE};
   row_t rows[8] = '{'{12'h800, 12'h100, 12'h800, 1, 1, 2'b11, 1},
      '{12'h800, 12'h100, 12'h7FF, 0, 1, 2'b11, 0}, '{12'h800, 12'h100, 12'h0FF, 1, 1, 2'b10, 1},
      '{12'h800, 12'h100, 12'h100, 0, 1, 2'b01, 0}, '{12'h100, 12'h800, 12'h100, 1, 1, 2'b01, 1},
      '{12'h100, 12'h800, 12'h400, 0, 1, 2'b00, 1}, '{12'h100, 12'h800, 12'h900, 1, 1, 2'b11, 0},
      '{12'h800, 12'h100, 12'hFFF, 0, 0, 2'b11, 0}};
   adc_sequencer_control DUT (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .trigLines(trigLines), .chanEnable(chanEnable), .coreReq(coreReq), .coreAns(coreAns),
      .irq(irq));
   analog_core_model core (.clk_sys(clk_sys), .resetn(resetn), .req(coreReq), .value(value),
      .lat(lat), .ans(coreAns));
   initial forever #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      if (coreReq.start)
         starts.push_back(coreReq.channel);
   end
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(negedge clk_sys);
      d = regRdata;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
         num_errors++;
      end
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
      logic [31:0] v;
      rd(a, v);
      chk(n, e, v & m);
   endtask
   // Bounded poll; a stuck bit shows up as a mismatch, not a hang
   task poll(input logic [7:0] a, input int b);
      logic [31:0] v;
      v = '1;
      for (int i = 0; i < 300 && v[b] !== 1'b0; i++)
         rd(a, v);
      chk("idle", 32'h0, {31'h0, v[b]});
   endtask
   task pulse(input logic [4:0] k);
      @(posedge clk_sys);
      trigLines <= 18'h1 << k;
      repeat (3) @(posedge clk_sys);
      trigLines <= '0;
   endtask
   task tend(input string n);
      $display("test %s done, errors %0d", n, num_errors);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      finish_test;
   end
   initial
   begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         value <= rows[i].dat;
         wr(OFS_LIMITS, {4'h0, rows[i].up, 4'h0, rows[i].low});
         wr(OFS_CONFIG, {30'h0, rows[i].we, 1'b1});
         wr(OFS_CONTROL, {20'h0, rows[i].al, 11'h100} | {30'h0, rows[i].ie});
         poll(OFS_CONTROL, CR_GO);
         rchk(OFS_STATUS, 32'h7, {30'h0, rows[i].win, 1'b1}, "status");
         chk("irq", {31'h0, |(rows[i].ie & {rows[i].win, 1'b1})}, {31'h0, irq});
         rchk(OFS_RESULT0, '1, {12'h020, rows[i].al ? {rows[i].dat, 4'h0}
            : {4'h0, rows[i].dat}}, "result");
         wr(OFS_STATUS, 32'h3);
         rchk(OFS_STATUS, 32'h3, 32'h0, "flags");
         tend("row");
      end
      chanEnable <= 9'h111;
      lat <= 4'h5;
      value <= 12'h300;
      starts.delete();
      wr(OFS_CONTROL, 32'h300);
      rchk(OFS_STATUS, 32'h5, 32'h4, "midscan");
      poll(OFS_CONTROL, CR_GO);
      rchk(OFS_STATUS, 32'h0001_FF01, 32'h0001_1101, "group");
      chk("order", 32'h048, {20'h0, starts[0], starts[1], starts[2]});
      wr(OFS_CONTROL, 32'h300);
      poll(OFS_CONTROL, CR_GO);
      rchk(OFS_STATUS, 32'h1FF0_0000, 32'h1110_0000, "overrun");
      rchk(8'h28, '1, 32'h0030_0304, "ovrres");
      rchk(8'h28, '1, 32'h0000_0304, "cleared");
      tend("scan");
      lat <= 4'h2;
      starts.delete();
      wr(OFS_CONTROL, 32'h500);
      for (int i = 0; i < 400 && starts.size() < 7; i++)
         @(posedge clk_sys);
      rchk(OFS_CONTROL, 32'h100, 32'h100, "running");
      wr(OFS_CONTROL, 32'h400);
      poll(OFS_STATUS, ST_BUSY);
      chk("passes", 32'h1, {31'h0, starts.size() >= 7});
      wr(OFS_STATUS, 32'h3);
      tend("continuous");
      chanEnable <= 9'h001;
      lat <= 4'h1;
      for (int k = 0; k < 3; k++)
      begin
         starts.delete();
         wr(OFS_CONTROL, 32'h104 | {13'h0, codes[k][4:3], 10'h0, codes[k][2:0], 4'h0});
         pulse(codes[k] ^ 5'h01);
         repeat (8) @(posedge clk_sys);
         chk("notrig", 32'h0, 32'(starts.size()));
         pulse(codes[k]);
         poll(OFS_CONTROL, CR_GO);
         chk("trig", 32'h1, 32'(starts.size()));
      end
      tend("trigger");
      starts.delete();
      wr(OFS_SLOT_LOW, 32'h0000_0537);
      wr(OFS_SLOT_COUNT, 32'h2);
      wr(OFS_SLOT_MODE, 32'h1);
      wr(OFS_CONTROL, 32'h300);
      poll(OFS_CONTROL, CR_GO);
      chk("slots", 32'h735, {20'h0, starts[0], starts[1], starts[2]});
      poll(OFS_STATUS, ST_BUSY);
      wr(OFS_SLOT_MODE, 32'h0);
      tend("slots");
      wr(OFS_LIMITS, 32'hFFFF_FFFF);
      rchk(OFS_LIMITS, '1, 32'h0FFF_0FFF, "limits");
      rchk(8'h0C, '1, 32'h0, "unmapped");
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      for (int k = 0; k < 7; k++)
         rchk(regs[k], '1, RESET_WORD, "reset");
      tend("reset");
      finish_test;
   end
endmodule
